// ==== shared/alu_pkg.sv ====
// Package for the rotate, subtract and skip datapath.
// Assumes one instruction issued per clock by the surrounding core.
package alu_pkg;

    typedef enum logic [4:0] {
        op_none = 5'h00,
        op_rotate_left_thru_carry_mem = 5'h01,
        op_rotate_left_thru_carry_wreg = 5'h02,
        op_rotate_right_mem = 5'h03,
        op_rotate_right_wreg = 5'h04,
        op_rotate_right_thru_carry_mem = 5'h05,
        op_rotate_right_thru_carry_wreg = 5'h06,
        op_subtract_with_borrow = 5'h07,
        op_subtract_with_borrow_to_mem = 5'h08,
        op_subtract = 5'h09,
        op_subtract_to_mem = 5'h0a,
        op_subtract_immediate = 5'h0b,
        op_decrement_skip_zero = 5'h0c,
        op_decrement_skip_zero_wreg = 5'h0d,
        op_increment_skip_zero = 5'h0e,
        op_increment_skip_zero_wreg = 5'h0f,
        op_set_byte = 5'h10,
        op_set_bit = 5'h11,
        op_bit_set_skip = 5'h12,
        op_swap_nibbles = 5'h13
    } opcode_t;

    typedef struct packed {
        logic valid;
        opcode_t op;
        logic [7:0] operand;
        logic [7:0] immediate;
        logic [2:0] bit_select;
    } request_t;

    typedef struct packed {
        logic carry;
        logic nibble_half_flag;
        logic zero;
        logic signed_wrap_flag;
    } flags_t;

    typedef enum logic [1:0] {
        st_run = 2'b01,
        st_dummy = 2'b10
    } phase_t;

    localparam logic [7:0] wreg_reset = 8'h00;
    localparam logic [7:0] all_ones = 8'hff;
    localparam logic [7:0] one = 8'h01;
    localparam int skip_cycles = 2;
    localparam int plain_cycles = 1;

endpackage

// ==== logic/sub_adder.sv ====
// Eight-bit adder with nibble and sign carries for subtraction.
// Pure combinational; the caller inverts the subtrahend.
`timescale 1ns/10ps
module sub_adder (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    // Result
    output logic [7:0] sum,
    output logic carry_out,
    output logic half_out,
    output logic wrap_out
);
    logic [4:0] low;
    logic [3:0] high;
    logic [1:0] top;

    always_comb begin
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
        high = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low[4]};
        top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, high[3]};
        sum = {top[0], high[2:0], low[3:0]};
        carry_out = top[1];
        half_out = low[4];
        wrap_out = top[1] ^ high[3];
    end
endmodule

// ==== logic/rotate_sub_skip_alu.sv ====
// Execution datapath for rotates, subtracts, skips, sets and nibble swap.
// Assumes the core presents one request per clock and reads memory writes
// from the registered outputs one clock later.
// Notes on behaviour
// - Rotate left via carry to memory
// - Rotate left via carry into working register
// - Rotate right, bit 0 to bit 7, memory
// - Rotate right into working register, no flags
// - Nine-bit right rotate via carry to memory
// - Right rotate via carry into working register
// - Subtract with borrow, updates four flags
// - Subtract memory operand, updates four flags
// - Subtract immediate into working register
// - True skip adds one dummy cycle
// - Decrement memory, skip on zero
// - Decrement into working register, skip on zero
// - Increment memory, skip on zero
// - Increment into working register, skip on zero
// - Set whole byte to all ones
// - Set one selected bit only
// - Skip when selected bit is one
// - Swap nibbles in memory
`timescale 1ns/10ps
module rotate_sub_skip_alu (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Instruction request
    input wire alu_pkg::request_t request,
    // Working register and flags
    output logic [7:0] working_register,
    output alu_pkg::flags_t flags,
    // Memory write back
    output logic mem_write,
    output logic [7:0] mem_data,
    // Sequencing
    output logic discard_next,
    output logic busy
);
    import alu_pkg::*;

    typedef struct packed {
        logic [7:0] wreg;
        flags_t flags;
        logic mem_write;
        logic [7:0] mem_data;
        logic discard_next;
        phase_t phase;
    } state_t;

    state_t state;
    state_t next_state;

    logic [7:0] sub_b;
    logic sub_cin;
    logic [7:0] sub_sum;
    logic sub_carry;
    logic sub_half;
    logic sub_wrap;
    logic [7:0] dec_value;
    logic [7:0] inc_value;
    logic accept;

    always_comb begin
        sub_b = ~request.operand;
        sub_cin = 1'b1;
        if (request.op == op_subtract_immediate) begin
            sub_b = ~request.immediate;
        end
        if (request.op == op_subtract_with_borrow ||
            request.op == op_subtract_with_borrow_to_mem) begin
            sub_cin = state.flags.carry;
        end
    end

    sub_adder adder (
        .a(state.wreg),
        .b(sub_b),
        .carry_in(sub_cin),
        .sum(sub_sum),
        .carry_out(sub_carry),
        .half_out(sub_half),
        .wrap_out(sub_wrap)
    );

    assign dec_value = request.operand - one;
    assign inc_value = request.operand + one;
    assign accept = request.valid && state.phase == st_run;

    always_comb begin
        next_state = state;
        next_state.mem_write = 1'b0;
        next_state.discard_next = 1'b0;
        case (state.phase)
            st_dummy: begin
                next_state.phase = st_run;
            end
            default: begin
                next_state.phase = st_run;
            end
        endcase
        if (accept) begin
            case (request.op)
                op_rotate_left_thru_carry_mem: begin
                    next_state.mem_data = {request.operand[6:0], state.flags.carry};
                    next_state.mem_write = 1'b1;
                    next_state.flags.carry = request.operand[7];
                end
                op_rotate_left_thru_carry_wreg: begin
                    next_state.wreg = {request.operand[6:0], state.flags.carry};
                    next_state.flags.carry = request.operand[7];
                end
                op_rotate_right_mem: begin
                    next_state.mem_data = {request.operand[0], request.operand[7:1]};
                    next_state.mem_write = 1'b1;
                end
                op_rotate_right_wreg: begin
                    next_state.wreg = {request.operand[0], request.operand[7:1]};
                end
                op_rotate_right_thru_carry_mem: begin
                    next_state.mem_data = {state.flags.carry, request.operand[7:1]};
                    next_state.mem_write = 1'b1;
                    next_state.flags.carry = request.operand[0];
                end
                op_rotate_right_thru_carry_wreg: begin
                    next_state.wreg = {state.flags.carry, request.operand[7:1]};
                    next_state.flags.carry = request.operand[0];
                end
                op_subtract_with_borrow, op_subtract, op_subtract_immediate: begin
                    next_state.wreg = sub_sum;
                    next_state.flags.carry = sub_carry;
                    next_state.flags.nibble_half_flag = sub_half;
                    next_state.flags.signed_wrap_flag = sub_wrap;
                    next_state.flags.zero = sub_sum == 8'h00;
                end
                op_subtract_with_borrow_to_mem, op_subtract_to_mem: begin
                    next_state.mem_data = sub_sum;
                    next_state.mem_write = 1'b1;
                    next_state.flags.carry = sub_carry;
                    next_state.flags.nibble_half_flag = sub_half;
                    next_state.flags.signed_wrap_flag = sub_wrap;
                    next_state.flags.zero = sub_sum == 8'h00;
                end
                op_decrement_skip_zero: begin
                    next_state.mem_data = dec_value;
                    next_state.mem_write = 1'b1;
                    next_state.discard_next = dec_value == 8'h00;
                end
                op_decrement_skip_zero_wreg: begin
                    next_state.wreg = dec_value;
                    next_state.discard_next = dec_value == 8'h00;
                end
                op_increment_skip_zero: begin
                    next_state.mem_data = inc_value;
                    next_state.mem_write = 1'b1;
                    next_state.discard_next = inc_value == 8'h00;
                end
                op_increment_skip_zero_wreg: begin
                    next_state.wreg = inc_value;
                    next_state.discard_next = inc_value == 8'h00;
                end
                op_set_byte: begin
                    next_state.mem_data = all_ones;
                    next_state.mem_write = 1'b1;
                end
                op_set_bit: begin
                    next_state.mem_data = request.operand | (one << request.bit_select);
                    next_state.mem_write = 1'b1;
                end
                op_bit_set_skip: begin
                    next_state.discard_next = request.operand[request.bit_select];
                end
                op_swap_nibbles: begin
                    next_state.mem_data = {request.operand[3:0], request.operand[7:4]};
                    next_state.mem_write = 1'b1;
                end
                default: begin
                    next_state.mem_write = 1'b0;
                end
            endcase
            if (next_state.discard_next) begin
                next_state.phase = st_dummy;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state.wreg <= wreg_reset;
            state.flags <= '0;
            state.mem_write <= 1'b0;
            state.mem_data <= wreg_reset;
            state.discard_next <= 1'b0;
            state.phase <= st_run;
        end else begin
            state <= next_state;
        end
    end

    assign working_register = state.wreg;
    assign flags = state.flags;
    assign mem_write = state.mem_write;
    assign mem_data = state.mem_data;
    assign discard_next = state.discard_next;
    assign busy = state.phase[1];

    property p_rlc_mem;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_left_thru_carry_mem) |=>
            mem_write && mem_data == {$past(request.operand[6:0]), $past(flags.carry)}
            && flags.carry == $past(request.operand[7]);
    endproperty
    a_rlc_mem: assert property (p_rlc_mem) else $error("rotate left via carry wrong");

    property p_rlc_wreg;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_left_thru_carry_wreg) |=>
            !mem_write && flags.carry == $past(request.operand[7])
            && working_register == {$past(request.operand[6:0]), $past(flags.carry)};
    endproperty
    a_rlc_wreg: assert property (p_rlc_wreg) else $error("rotate left wreg wrong");

    property p_rr_mem;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_right_mem) |=>
            mem_write && mem_data[7] == $past(request.operand[0]) && $stable(flags);
    endproperty
    a_rr_mem: assert property (p_rr_mem) else $error("rotate right memory wrong");

    property p_rrc_mem;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_right_thru_carry_mem) |=>
            mem_data[7] == $past(flags.carry) && flags.carry == $past(request.operand[0]);
    endproperty
    a_rrc_mem: assert property (p_rrc_mem) else $error("rotate right via carry wrong");

    property p_sub;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_subtract) |=>
            working_register == $past(working_register) - $past(request.operand)
            && flags.carry == ($past(working_register) >= $past(request.operand));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result or carry wrong");

    property p_skip_dummy;
        @(posedge clock) disable iff (reset)
        discard_next |-> busy ##1 !busy;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip not two cycles");

    property p_inc_skip;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_increment_skip_zero) |=>
            discard_next == ($past(request.operand) == 8'hff) && $stable(flags);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

    property p_set_byte;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_set_byte) |=> mem_write && mem_data == 8'hff;
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("set byte wrong");

    property p_bit_skip;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_bit_set_skip) |=>
            discard_next == $past(request.operand[request.bit_select]) && !mem_write;
    endproperty
    a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

    property p_rr_wreg;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_right_wreg) |=>
            !mem_write && $stable(flags)
            && working_register == {$past(request.operand[0]), $past(request.operand[7:1])};
    endproperty
    a_rr_wreg: assert property (p_rr_wreg) else $error("rotate right wreg wrong");

    property p_rrc_wreg;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_rotate_right_thru_carry_wreg) |=>
            !mem_write && flags.carry == $past(request.operand[0])
            && working_register == {$past(flags.carry), $past(request.operand[7:1])};
    endproperty
    a_rrc_wreg: assert property (p_rrc_wreg) else $error("rotate right via carry wreg wrong");

    property p_sbc_mem;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_subtract_with_borrow_to_mem) |=>
            mem_write && $stable(working_register)
            && mem_data == 8'($past(working_register) + 8'(~$past(request.operand))
                + 8'($past(flags.carry)))
            && flags.carry == ({1'b0, $past(working_register)} + {8'h00, $past(flags.carry)}
                > {1'b0, $past(request.operand)})
            && flags.zero == (mem_data == 8'h00);
    endproperty
    a_sbc_mem: assert property (p_sbc_mem) else $error("subtract with borrow to memory wrong");

    property p_sub_imm;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_subtract_immediate) |=>
            working_register == 8'($past(working_register) - $past(request.immediate))
            && flags.carry == ($past(working_register) >= $past(request.immediate))
            && flags.zero == (working_register == 8'h00);
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("subtract immediate wrong");

    property p_dummy_ignored;
        @(posedge clock) disable iff (reset)
        busy |=> !mem_write && !discard_next && $stable(working_register) && $stable(flags);
    endproperty
    a_dummy_ignored: assert property (p_dummy_ignored) else $error("dummy cycle not idle");

    property p_dec_mem;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_decrement_skip_zero) |=>
            mem_write && mem_data == 8'($past(request.operand) - 8'h01) && $stable(flags)
            && discard_next == ($past(request.operand) == 8'h01);
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("decrement skip wrong");

    property p_dec_wreg;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_decrement_skip_zero_wreg) |=>
            !mem_write && working_register == 8'($past(request.operand) - 8'h01)
            && discard_next == ($past(request.operand) == 8'h01) && $stable(flags);
    endproperty
    a_dec_wreg: assert property (p_dec_wreg) else $error("decrement skip wreg wrong");

    property p_inc_wreg;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_increment_skip_zero_wreg) |=>
            !mem_write && working_register == 8'($past(request.operand) + 8'h01)
            && discard_next == ($past(request.operand) == 8'hff) && $stable(flags);
    endproperty
    a_inc_wreg: assert property (p_inc_wreg) else $error("increment skip wreg wrong");

    property p_set_bit;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_set_bit) |=>
            mem_write && mem_data[$past(request.bit_select)] && $stable(flags)
            && (mem_data & $past(request.operand)) == $past(request.operand)
            && $countones(mem_data ^ $past(request.operand)) <= 1;
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("set bit wrong");

    property p_swap;
        @(posedge clock) disable iff (reset)
        (accept && request.op == op_swap_nibbles) |=>
            mem_write && $stable(flags)
            && mem_data == {$past(request.operand[3:0]), $past(request.operand[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    c_skip: cover property (@(posedge clock) disable iff (reset) discard_next);
    c_sub_borrow: cover property (@(posedge clock) disable iff (reset)
        accept && request.op == op_subtract_with_borrow);
    c_swap: cover property (@(posedge clock) disable iff (reset)
        accept && request.op == op_swap_nibbles);
endmodule

// ==== verification/test_rotate_sub_skip_alu.sv ====
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes registered outputs that answer on the edge that takes a request.
`timescale 1ns/10ps
module test_rotate_sub_skip_alu;
    import alu_pkg::*;
    logic clock;
    logic reset;
    request_t request;
    logic [7:0] working_register;
    flags_t flags;
    logic mem_write;
    logic [7:0] mem_data;
    logic discard_next;
    logic busy;
    int errors;
    int num_checks;
    logic [7:0] ew;
    flags_t ef;
    logic [7:0] em;

    rotate_sub_skip_alu dut (.clock(clock), .reset(reset), .request(request),
        .working_register(working_register), .flags(flags), .mem_write(mem_write),
        .mem_data(mem_data), .discard_next(discard_next), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_of_test;
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_all(input logic mw, input logic skip);
        chk("working_register", ew, working_register);
        chk("flags", {4'h0, ef}, {4'h0, flags});
        chk("mem_write", {7'h00, mw}, {7'h00, mem_write});
        chk("mem_data", em, mem_data);
        chk("discard_next", {7'h00, skip}, {7'h00, discard_next});
        chk("busy", {7'h00, skip}, {7'h00, busy});
    endtask

    // Flags then result: carry, half, zero, wrap, byte
    function automatic logic [11:0] sub_model(input logic [7:0] a, input logic [7:0] b,
                                              input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] l;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        l = {1'b0, a[6:0]} + {1'b0, ~b[6:0]} + {7'h00, cin};
        return {s[8], h[4], s[7:0] == 8'h00, l[7] ^ s[8], s[7:0]};
    endfunction

    // Presents one request, checks the answer and any dummy cycle after it
    task automatic exec(input opcode_t code, input logic [7:0] opnd, input logic [7:0] imm,
                        input logic [2:0] bs);
        logic mw;
        logic skip;
        logic [7:0] res;
        res = 8'h00;
        case (code)
            op_rotate_left_thru_carry_mem, op_rotate_left_thru_carry_wreg: begin
                res = {opnd[6:0], ef.carry};
                ef.carry = opnd[7];
            end
            op_rotate_right_mem, op_rotate_right_wreg: res = {opnd[0], opnd[7:1]};
            op_rotate_right_thru_carry_mem, op_rotate_right_thru_carry_wreg: begin
                res = {ef.carry, opnd[7:1]};
                ef.carry = opnd[0];
            end
            op_subtract_with_borrow, op_subtract_with_borrow_to_mem:
                {ef, res} = sub_model(ew, opnd, ef.carry);
            op_subtract, op_subtract_to_mem: {ef, res} = sub_model(ew, opnd, 1'b1);
            op_subtract_immediate: {ef, res} = sub_model(ew, imm, 1'b1);
            op_decrement_skip_zero, op_decrement_skip_zero_wreg: res = opnd - 8'h01;
            op_increment_skip_zero, op_increment_skip_zero_wreg: res = opnd + 8'h01;
            op_set_byte: res = 8'hff;
            op_set_bit: res = opnd | (8'h01 << bs);
            op_swap_nibbles: res = {opnd[3:0], opnd[7:4]};
            default: res = 8'h00;
        endcase
        mw = code inside {op_rotate_left_thru_carry_mem, op_rotate_right_mem,
            op_rotate_right_thru_carry_mem, op_subtract_with_borrow_to_mem, op_subtract_to_mem,
            op_decrement_skip_zero, op_increment_skip_zero, op_set_byte, op_set_bit,
            op_swap_nibbles};
        if (code inside {op_rotate_left_thru_carry_wreg, op_rotate_right_wreg,
            op_rotate_right_thru_carry_wreg, op_subtract_with_borrow, op_subtract,
            op_subtract_immediate, op_decrement_skip_zero_wreg, op_increment_skip_zero_wreg}) begin
            ew = res;
        end
        if (mw) begin
            em = res;
        end
        skip = (code inside {op_decrement_skip_zero, op_decrement_skip_zero_wreg,
            op_increment_skip_zero, op_increment_skip_zero_wreg} && res == 8'h00)
            || (code == op_bit_set_skip && opnd[bs]);
        request = '{valid: 1'b1, op: code, operand: opnd, immediate: imm, bit_select: bs};
        @(posedge clock);
        #1;
        check_all(mw, skip);
        if (skip) begin
            // Request is still held during the dummy cycle and must be ignored
            @(posedge clock);
            #1;
            check_all(1'b0, 1'b0);
        end
    endtask

    task automatic t_rotates;
        exec(op_rotate_left_thru_carry_mem, 8'h81, 8'h00, 3'h0);
        exec(op_rotate_left_thru_carry_wreg, 8'h40, 8'h00, 3'h0);
        exec(op_rotate_right_mem, 8'h01, 8'h00, 3'h0);
        exec(op_rotate_right_wreg, 8'h02, 8'h00, 3'h0);
        exec(op_rotate_right_thru_carry_mem, 8'h01, 8'h00, 3'h0);
        exec(op_rotate_right_thru_carry_wreg, 8'h00, 8'h00, 3'h0);
    endtask

    task automatic t_subtracts;
        exec(op_subtract_immediate, 8'h00, 8'h01, 3'h0);
        exec(op_subtract, 8'h80, 8'h00, 3'h0);
        exec(op_subtract_with_borrow, 8'h00, 8'h00, 3'h0);
        exec(op_subtract_with_borrow_to_mem, 8'hfe, 8'h00, 3'h0);
        exec(op_subtract_to_mem, 8'h01, 8'h00, 3'h0);
        exec(op_subtract, 8'h18, 8'h00, 3'h0);
    endtask

    task automatic t_skips;
        exec(op_decrement_skip_zero, 8'h01, 8'h00, 3'h0);
        exec(op_decrement_skip_zero, 8'h00, 8'h00, 3'h0);
        exec(op_decrement_skip_zero_wreg, 8'h01, 8'h00, 3'h0);
        exec(op_decrement_skip_zero_wreg, 8'h10, 8'h00, 3'h0);
        exec(op_increment_skip_zero, 8'hff, 8'h00, 3'h0);
        exec(op_increment_skip_zero, 8'h7f, 8'h00, 3'h0);
        exec(op_increment_skip_zero_wreg, 8'h7f, 8'h00, 3'h0);
        exec(op_increment_skip_zero_wreg, 8'hff, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) begin
            exec(op_bit_set_skip, 8'h80, 8'h00, 3'(i));
        end
    endtask

    task automatic t_sets;
        exec(op_set_byte, 8'h00, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) begin
            exec(op_set_bit, 8'h24, 8'h00, 3'(i));
        end
        exec(op_swap_nibbles, 8'h3c, 8'h00, 3'h0);
        exec(op_none, 8'h55, 8'h00, 3'h0);
    endtask

    task automatic t_idle;
        request.valid = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check_all(1'b0, 1'b0);
    endtask

    task automatic t_midrun_reset;
        request = '{valid: 1'b1, op: op_set_byte, operand: 8'h00, immediate: 8'h00,
                    bit_select: 3'h0};
        reset = 1'b1;
        @(posedge clock);
        #1;
        reset = 1'b0;
        ew = 8'h00;
        ef = '0;
        em = 8'h00;
        check_all(1'b0, 1'b0);
        exec(op_rotate_left_thru_carry_wreg, 8'h80, 8'h00, 3'h0);
    endtask

    initial begin
        repeat (2000) @(posedge clock);
        errors++;
        end_of_test();
    end

    initial begin
        reset = 1'b1;
        request = '0;
        errors = 0;
        num_checks = 0;
        ew = 8'h00;
        ef = '0;
        em = 8'h00;
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        check_all(1'b0, 1'b0);
        t_rotates();
        t_subtracts();
        t_skips();
        t_sets();
        t_idle();
        t_midrun_reset();
        end_of_test();
    end
endmodule
